// file: ccr_pkg.sv
// Constants for the converter configuration register bank.
// Assumes an 8-bit register address and 16-bit register data.
package ccr_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned CCR_ADDR_W = 8;
  localparam int unsigned CCR_DATA_W = 16;
  localparam int unsigned CCR_LANES = 16;
  localparam int unsigned CCR_PE_W = 3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] CCR_RANGE_B_OFS = 8'h32;
  localparam logic [7:0] CCR_REF_SRC_OFS = 8'h38;
  localparam logic [7:0] CCR_STAMP_OFS = 8'h3B;
  localparam logic [7:0] CCR_EMPH_OFS = 8'h48;
  localparam logic [7:0] CCR_ROUTE_OFS = 8'h60;
  localparam logic [7:0] CCR_STATUS_OFS = 8'h70;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] CCR_RANGE_B_RST = 16'hA000;
  localparam logic [7:0] CCR_REF_SRC_RST = 8'h00;
  localparam logic [7:0] CCR_STAMP_RST = 8'h00;
  localparam logic [7:0] CCR_EMPH_RST = 8'h00;
  localparam logic [7:0] CCR_ROUTE_RST = 8'h01;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CCR_REF_BYPASS_BIT = 0;
  localparam int unsigned CCR_STAMP_RECV_BIT = 0;
  localparam int unsigned CCR_STAMP_PECL_BIT = 1;
  localparam int unsigned CCR_PE_LSB = 0;
  localparam int unsigned CCR_PE_BOOST_BIT = 3;
  localparam int unsigned CCR_SWAP_BIT = 4;
  localparam int unsigned CCR_SINGLE_LSB = 0;
  localparam int unsigned CCR_STAT_PEND_BIT = 0;
  localparam int unsigned CCR_STAT_ASRC_BIT = 1;
  localparam int unsigned CCR_STAT_BSRC_BIT = 2;
  localparam int unsigned CCR_STAT_BON_BIT = 3;

  // ****************************************************************
  // Single-channel input selector codes
  // ****************************************************************
  typedef enum logic [1:0] {
    CCR_SEL_RESERVED = 2'h0,
    CCR_SEL_INPUT_A = 2'h1,
    CCR_SEL_INPUT_B = 2'h2,
    CCR_SEL_BOTH = 2'h3
  } ccr_single_sel_t;

  // Source encoding for a channel
  localparam logic CCR_SRC_A = 1'b0;
  localparam logic CCR_SRC_B = 1'b1;

endpackage

// file: ccr_lane_emphasis.sv
// One serializer lane's registered pre-emphasis setting.
// Assumes level and boost come from the shared global register.
`timescale 1ns/1ps
module ccr_lane_emphasis
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Shared setting
  input wire logic [CCR_PE_W-1:0] level,
  input wire logic boost,
  // Lane setting, boost on top
  output logic [CCR_PE_W:0] lane_setting
);

  // Every lane copies the same global value; no per-lane field exists
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lane_setting <= '0;
    end
    else
    begin
      lane_setting <= {boost, level}; // RULE_06
    end
  end

endmodule

// file: ccr_config_regs.sv
// Converter configuration register bank: range, reference, timestamp,
// serializer emphasis and input routing controls.
// Assumes a plain register port with one-cycle strobes and read data
// returned in the following cycle; link mode and calibration enable
// arrive as synchronous levels from the rest of the converter.
// Calibration itself and the converter core live elsewhere;
// this bank only holds settings and gates routing changes.
//
// How it works
// RULE_01 - 16-bit input B range code, read/write, resets to 0xA000.
// RULE_02 - Software keeps range code within 0x2000..0xFFFF; lower still accepted.
// RULE_03 - Reference bypass bit selects 1.1 V supply as reference.
// RULE_04 - Timestamp receiver enabled only while its bit is set, default off.
// RULE_05 - Second timestamp bit puts receiver into low-voltage PECL mode.
// RULE_06 - One 3-bit emphasis value drives all sixteen lanes alike.
// RULE_07 - Boost bit raises and lengthens emphasis beyond the level.
// RULE_08 - Dual mode: swap bit clear routes straight, set swaps inputs.
// RULE_09 - Swap bit ignored while link mode is single-channel.
// RULE_10 - Single mode selector: 1 A, 2 B, 3 both; 0 reserved.
// RULE_11 - Single selector ignored while link mode is dual-channel.
// RULE_12 - New routing takes effect only when calibration is started.
// RULE_13 - Software starts calibration by raising calibration enable.
// RULE_14 - Reserved bits store written values with no effect; changed reserved routing bits still set routing_pending.
`timescale 1ns/1ps
module ccr_config_regs
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [CCR_ADDR_W-1:0] reg_addr,
  input wire logic [CCR_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [CCR_DATA_W-1:0] reg_rdata,
  // Converter context
  input wire logic link_mode_single,
  input wire logic calibration_enable,
  // Analog controls
  output logic [15:0] channel_b_range_code,
  output logic reference_bypass_bit,
  output logic stamp_input_receiver_on,
  output logic stamp_input_pecl_select,
  // Serializer lane settings, 4 bits per lane, boost in the top bit
  output logic [CCR_LANES*(CCR_PE_W+1)-1:0] lane_emphasis_setting,
  // Applied input routing
  output logic channel_a_source,
  output logic channel_b_source,
  output logic channel_b_sampling,
  output logic routing_pending
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] range_b_reg;
  logic [7:0] ref_src_reg;
  logic [7:0] stamp_reg;
  logic [7:0] emph_reg;
  logic [7:0] route_reg;
  logic [7:0] route_applied_reg;
  logic cal_enable_prev_reg;
  logic cal_start;
  logic route_change;
  logic [CCR_PE_W-1:0] lane_emphasis_level;
  logic lane_emphasis_extra;
  logic [1:0] single_sel;
  logic swap_sel;
  logic a_src_next;
  logic b_src_next;
  logic b_on_next;
  logic [CCR_DATA_W-1:0] rdata_next;

  // Write decode helpers
  logic wr_range;
  logic wr_ref;
  logic wr_stamp;
  logic wr_emph;
  logic wr_route;

  // Exact decode; unmapped offsets match nothing, so stray
  // writes fall away without side effects
  assign wr_range = reg_write && (reg_addr == CCR_RANGE_B_OFS);
  assign wr_ref = reg_write && (reg_addr == CCR_REF_SRC_OFS);
  assign wr_stamp = reg_write && (reg_addr == CCR_STAMP_OFS);
  assign wr_emph = reg_write && (reg_addr == CCR_EMPH_OFS);
  assign wr_route = reg_write && (reg_addr == CCR_ROUTE_OFS);

  // ****************************************************************
  // Software-written registers
  // ****************************************************************

  // Range code; any value is accepted, range is software's job
  // Codes under the recommended floor are kept, not clamped
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      range_b_reg <= CCR_RANGE_B_RST; // RULE_01
    end
    else if (wr_range)
    begin
      range_b_reg <= reg_wdata; // RULE_01
    end
  end

  // Byte registers keep reserved bits as written
  // Upper write byte is ignored by these 8-bit registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_src_reg <= CCR_REF_SRC_RST;
      stamp_reg <= CCR_STAMP_RST; // RULE_04
      emph_reg <= CCR_EMPH_RST;
      route_reg <= CCR_ROUTE_RST;
    end
    else
    begin
      if (wr_ref)
      begin
        ref_src_reg <= reg_wdata[7:0]; // RULE_14
      end
      if (wr_stamp)
      begin
        stamp_reg <= reg_wdata[7:0]; // RULE_14
      end
      if (wr_emph)
      begin
        emph_reg <= reg_wdata[7:0]; // RULE_14
      end
      if (wr_route)
      begin
        route_reg <= reg_wdata[7:0]; // RULE_14
      end
    end
  end

  // ****************************************************************
  // Analog control outputs
  // ****************************************************************

  // Registered copies so outputs come straight from flops
  // One cycle of lag traded for clean flop-driven pins
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      channel_b_range_code <= CCR_RANGE_B_RST;
      reference_bypass_bit <= CCR_REF_SRC_RST[CCR_REF_BYPASS_BIT];
      stamp_input_receiver_on <= CCR_STAMP_RST[CCR_STAMP_RECV_BIT]; // RULE_04
      stamp_input_pecl_select <= CCR_STAMP_RST[CCR_STAMP_PECL_BIT];
    end
    else
    begin
      channel_b_range_code <= range_b_reg; // RULE_01
      reference_bypass_bit <= ref_src_reg[CCR_REF_BYPASS_BIT]; // RULE_03
      stamp_input_receiver_on <= stamp_reg[CCR_STAMP_RECV_BIT]; // RULE_04
      stamp_input_pecl_select <= stamp_reg[CCR_STAMP_PECL_BIT]; // RULE_05
    end
  end

  // ****************************************************************
  // Serializer emphasis, one global value fanned to all lanes
  // ****************************************************************
  // Limitation: no lane can be trimmed on its own
  assign lane_emphasis_level = emph_reg[CCR_PE_LSB +: CCR_PE_W];
  assign lane_emphasis_extra = emph_reg[CCR_PE_BOOST_BIT]; // RULE_07

  genvar lane;
  generate
    for (lane = 0; lane < CCR_LANES; lane = lane + 1)
    begin : g_lane
      ccr_lane_emphasis u_lane (
        .clock(clock),
        .reset_n(reset_n),
        .level(lane_emphasis_level),
        .boost(lane_emphasis_extra),
        .lane_setting(
          lane_emphasis_setting[lane*(CCR_PE_W+1) +: (CCR_PE_W+1)])
      ); // RULE_06
    end
  endgenerate

  // ****************************************************************
  // Calibration start detect and routing hold-off
  // ****************************************************************

  // Rising edge of calibration enable marks a calibration run
  // Reset high: a level already high at release is no start
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cal_enable_prev_reg <= 1'b1;
    end
    else
    begin
      cal_enable_prev_reg <= calibration_enable;
    end
  end

  assign cal_start = calibration_enable && !cal_enable_prev_reg; // RULE_13

  // Rewriting the stored value is no change and raises nothing
  assign route_change = wr_route && (reg_wdata[7:0] != route_reg);

  // Routing copy only refreshed by a calibration start
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      route_applied_reg <= CCR_ROUTE_RST;
    end
    else if (cal_start)
    begin
      route_applied_reg <= route_reg; // RULE_12
    end
  end

  // Pending flag; a change in the start cycle stays pending (set wins)
  // Cleared by a calibration start only
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      routing_pending <= 1'b0;
    end
    else if (route_change)
    begin
      routing_pending <= 1'b1; // RULE_12
    end
    else if (cal_start)
    begin
      routing_pending <= 1'b0; // RULE_12
    end
  end

  // ****************************************************************
  // Channel routing from the applied selection
  // ****************************************************************
  assign single_sel = route_applied_reg[CCR_SINGLE_LSB +: 2];
  assign swap_sel = route_applied_reg[CCR_SWAP_BIT];

  // Selector only in single mode, swap only in dual mode
  always_comb
  begin
    a_src_next = CCR_SRC_A;
    b_src_next = CCR_SRC_B;
    b_on_next = 1'b1;
    if (link_mode_single)
    begin
      // Reserved code 0 falls back to input A, the safe default
      unique case (single_sel)
        CCR_SEL_INPUT_B:
        begin
          a_src_next = CCR_SRC_B; // RULE_10
          b_on_next = 1'b0;
        end
        CCR_SEL_BOTH:
        begin
          a_src_next = CCR_SRC_A; // RULE_10
          b_src_next = CCR_SRC_B;
        end
        CCR_SEL_INPUT_A, CCR_SEL_RESERVED:
        begin
          a_src_next = CCR_SRC_A; // RULE_10
          b_on_next = 1'b0;
        end
      endcase
      // Swap bit has no say here
    end
    else
    begin
      // Selector has no say here
      a_src_next = swap_sel ? CCR_SRC_B : CCR_SRC_A; // RULE_08 RULE_11
      b_src_next = swap_sel ? CCR_SRC_A : CCR_SRC_B; // RULE_08
    end
  end

  // Routing outputs; swap ignored in single mode by the branch above
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      channel_a_source <= CCR_SRC_A;
      channel_b_source <= CCR_SRC_B;
      channel_b_sampling <= 1'b1;
    end
    else
    begin
      channel_a_source <= a_src_next; // RULE_09
      channel_b_source <= b_src_next; // RULE_09
      channel_b_sampling <= b_on_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Unmapped addresses read as zero
  // Status mirrors the routing flops, so it lags by one cycle
  always_comb
  begin
    rdata_next = '0;
    unique case (reg_addr)
      CCR_RANGE_B_OFS: rdata_next = range_b_reg;
      CCR_REF_SRC_OFS: rdata_next[7:0] = ref_src_reg;
      CCR_STAMP_OFS: rdata_next[7:0] = stamp_reg;
      CCR_EMPH_OFS: rdata_next[7:0] = emph_reg;
      CCR_ROUTE_OFS: rdata_next[7:0] = route_reg;
      CCR_STATUS_OFS:
      begin
        rdata_next[CCR_STAT_PEND_BIT] = routing_pending;
        rdata_next[CCR_STAT_ASRC_BIT] = channel_a_source;
        rdata_next[CCR_STAT_BSRC_BIT] = channel_b_source;
        rdata_next[CCR_STAT_BON_BIT] = channel_b_sampling;
      end
      default: rdata_next = '0;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  // Zero outside the read slot keeps the bus quiet
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= '0;
    end
    else if (reg_read)
    begin
      reg_rdata <= rdata_next;
    end
    else
    begin
      reg_rdata <= '0;
    end
  end

endmodule

// file: ccr_config_regs_properties.sv
// Checker for the converter configuration register bank.
// Assumes it is bound to ccr_config_regs and sees only its ports.
`timescale 1ns/1ps
module ccr_config_regs_checker
  import ccr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [CCR_ADDR_W-1:0] reg_addr,
  input wire logic [CCR_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [CCR_DATA_W-1:0] reg_rdata,
  // Converter context
  input wire logic link_mode_single,
  input wire logic calibration_enable,
  // Controls
  input wire logic [15:0] channel_b_range_code,
  input wire logic reference_bypass_bit,
  input wire logic stamp_input_receiver_on,
  input wire logic stamp_input_pecl_select,
  input wire logic [CCR_LANES*(CCR_PE_W+1)-1:0] lane_emphasis_setting,
  input wire logic channel_a_source,
  input wire logic channel_b_source,
  input wire logic channel_b_sampling,
  input wire logic routing_pending
);
  // ******
  // Properties
  // ******
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Range, bypass, stamp and lane outputs may only move two edges after a matching write
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_range_write: assert property ($changed(channel_b_range_code) |->
    $past(reg_write, 2) && $past(reg_addr, 2) == CCR_RANGE_B_OFS &&
    channel_b_range_code == $past(reg_wdata, 2))
    else $error("range code moved without its write");
  a_bypass_write: assert property ($changed(reference_bypass_bit) |->
    $past(reg_write, 2) && $past(reg_addr, 2) == CCR_REF_SRC_OFS &&
    reference_bypass_bit == $past(reg_wdata[0], 2))
    else $error("bypass moved without its write");
  a_stamp_write: assert property ($changed({stamp_input_pecl_select,
    stamp_input_receiver_on}) |-> $past(reg_write, 2) &&
    {stamp_input_pecl_select, stamp_input_receiver_on} ==
    $past(reg_wdata[1:0], 2) && $past(reg_addr, 2) == CCR_STAMP_OFS)
    else $error("stamp controls moved without their write");
  a_lanes_equal: assert property (lane_emphasis_setting ==
    {16{lane_emphasis_setting[3:0]}})
    else $error("lanes differ");
  a_lanes_write: assert property ($changed(lane_emphasis_setting) |->
    $past(reg_write, 2) && $past(reg_addr, 2) == CCR_EMPH_OFS &&
    lane_emphasis_setting[3:0] == $past(reg_wdata[3:0], 2))
    else $error("lanes moved without their write");
  a_pending_set: assert property ($rose(routing_pending) |->
    $past(reg_write) && $past(reg_addr) == CCR_ROUTE_OFS)
    else $error("pending rose without route write");
  a_pending_clear: assert property (calibration_enable &&
    !$past(calibration_enable) && !(reg_write && reg_addr == CCR_ROUTE_OFS)
    |=> !routing_pending)
    else $error("pending kept after calibration start");
  a_route_hold: assert property ($changed({channel_a_source,
    channel_b_source, channel_b_sampling}) |-> $past(link_mode_single) !=
    $past(link_mode_single, 3) ||
    $past(calibration_enable, 2) && !$past(calibration_enable, 3))
    else $error("routing moved without calibration start");
  a_dual_route: assert property (!$past(link_mode_single) &&
    !$past(link_mode_single, 2) |-> channel_b_sampling &&
    channel_a_source != channel_b_source)
    else $error("dual routing malformed");
  a_b_off_src: assert property (!channel_b_sampling |-> channel_b_source)
    else $error("idle channel B source not parked");
  // Main scenarios reached
  cover property (reg_read ##1 reg_rdata != 16'h0000);
  cover property ($rose(routing_pending));
  cover property ($fell(routing_pending));
  cover property (calibration_enable && !$past(calibration_enable) &&
    reg_write && reg_addr == CCR_ROUTE_OFS);
endmodule

// file: ccr_config_regs_tb.sv
// Self-checking bench for the converter configuration register bank.
// Assumes the checker module is compiled before this file.
`timescale 1ns/1ps
module ccr_config_regs_tb;
  import ccr_pkg::*;
  logic clock, reset_n, reg_write, reg_read, link_mode_single;
  logic calibration_enable, reference_bypass_bit, stamp_input_receiver_on;
  logic stamp_input_pecl_select, channel_a_source, channel_b_source;
  logic channel_b_sampling, routing_pending;
  logic [7:0] reg_addr, stored, v;
  logic [15:0] reg_wdata, reg_rdata, channel_b_range_code, d;
  logic [63:0] lane_emphasis_setting;
  logic [2:0] x;
  logic [15:0] sh [4];
  logic [7:0] offs [4] = '{CCR_RANGE_B_OFS, CCR_REF_SRC_OFS, CCR_STAMP_OFS,
    CCR_EMPH_OFS};
  logic [15:0] corner [3] = '{16'h0000, 16'h2000, 16'hFFFF};
  int miscompares, comparisons;

  ccr_config_regs ccr_config_regs_i (.clock, .reset_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .link_mode_single,
    .calibration_enable, .channel_b_range_code, .reference_bypass_bit,
    .stamp_input_receiver_on, .stamp_input_pecl_select,
    .lane_emphasis_setting, .channel_a_source, .channel_b_source,
    .channel_b_sampling, .routing_pending);

  // ******
  // Clock, helpers and expectations
  // ******
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [15:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= ad;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(64'(reg_rdata), 64'(exp));
  endtask

  // Narrow registers drop the upper byte, reserved bits read back
  function automatic logic [15:0] rd_exp(logic [7:0] ad, logic [15:0] dt);
    return (ad == CCR_RANGE_B_OFS) ? dt : {8'h00, dt[7:0]};
  endfunction

  // Expected {channel A source, channel B source, channel B on}
  function automatic logic [2:0] route_exp(logic single, logic [7:0] r);
    if (!single)
      return r[4] ? 3'b101 : 3'b011;
    case (r[1:0])
      2'h2: return 3'b110;
      2'h3: return 3'b011;
      default: return 3'b010;
    endcase
  endfunction

  // Applied routing seen under both link modes
  task automatic route_both(input logic [7:0] r);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge clock);
      link_mode_single <= s[0];
      repeat (3) @(posedge clock);
      #1 check(64'({channel_a_source, channel_b_source, channel_b_sampling}),
        64'(route_exp(s[0], r)));
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ******
  // Main sequence
  // ******
  initial
  begin
    {reset_n, reg_write, reg_read, link_mode_single} = 4'h0;
    {calibration_enable, reg_addr, reg_wdata} = '0;
    miscompares = 0;
    comparisons = 0;
    void'($urandom(31958));
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    sh = '{CCR_RANGE_B_RST, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 4; i++)
      rd(offs[i], sh[i]);
    rd(CCR_ROUTE_OFS, 16'h0001);
    check(lane_emphasis_setting, 64'h0);
    $display("reset values done");
    // Unmapped place and read-only status ignore writes
    wr(8'h31, 16'hFFFF);
    rd(8'h31, 16'h0000);
    wr(CCR_STATUS_OFS, 16'hFFFF);
    rd(CCR_STATUS_OFS, 16'h000C);
    $display("unmapped access done");
    // Random data with range corner codes mixed in
    for (int i = 0; i < 24; i++)
    begin
      d = (i < 12 && i % 4 == 0) ? corner[i / 4] : 16'($urandom);
      wr(offs[i % 4], d);
      sh[i % 4] = rd_exp(offs[i % 4], d);
      rd(offs[i % 4], sh[i % 4]);
      @(posedge clock);
      #1 check(64'(channel_b_range_code), 64'(sh[0]));
      check(64'(reference_bypass_bit), 64'(sh[1][0]));
      check(64'({stamp_input_pecl_select, stamp_input_receiver_on}),
        64'(sh[2][1:0]));
      check(lane_emphasis_setting, {16{sh[3][3:0]}});
    end
    $display("register data done");
    // Every selector and swap code, applied only by calibration start
    stored = CCR_ROUTE_RST;
    for (int i = 0; i < 8; i++)
    begin
      v = {3'($urandom), i[2], 2'($urandom), i[1:0]};
      wr(CCR_ROUTE_OFS, {8'($urandom), v});
      repeat (2) @(posedge clock);
      #1 check(64'(routing_pending), 64'(v != stored));
      rd(CCR_ROUTE_OFS, {8'h00, v});
      route_both(stored);
      @(posedge clock);
      calibration_enable <= 1'b0;
      @(posedge clock);
      calibration_enable <= 1'b1;
      repeat (3) @(posedge clock);
      #1 check(64'(routing_pending), 64'h0);
      route_both(v);
      x = route_exp(1'b1, v);
      rd(CCR_STATUS_OFS, {12'h000, x[0], x[1], x[2], 1'b0});
      stored = v;
    end
    // Route write in the very cycle of a calibration start stays pending
    @(posedge clock);
    calibration_enable <= 1'b0;
    fork
      wr(CCR_ROUTE_OFS, {8'h00, ~stored});
      begin
        @(posedge clock);
        calibration_enable <= 1'b1;
      end
    join
    @(posedge clock);
    #1 check(64'(routing_pending), 64'h1);
    $display("routing done");
    finish_test;
  end

  // Hang guard
  initial
  begin
    repeat (50000) @(posedge clock);
    miscompares++;
    finish_test;
  end
endmodule

bind ccr_config_regs ccr_config_regs_checker ccr_config_regs_checker_i (
  .clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .link_mode_single, .calibration_enable,
  .channel_b_range_code, .reference_bypass_bit, .stamp_input_receiver_on,
  .stamp_input_pecl_select, .lane_emphasis_setting, .channel_a_source,
  .channel_b_source, .channel_b_sampling, .routing_pending);
